/* hdl/ccl_regs.sv */
// Per-channel local register set of a telephony codec, APB slave
//
// Behaviour
// - Five enables gate bidir-pin and supervision change interrupts; reset cleared.
// - Bidir pin change interrupts only while that pin is an input.
// - Loopback bits 2..0: timeslot digital, onebit analog, onebit digital; reset off.
// - Hook debounce time is low nibble times 2 ms, reset 0.
// - Ground-key interval is high nibble times 2 ms; min debounce up to 180 ms.
// - Pin data shows outputs, bidir pins and supervision inputs; bit 7 reserved.
// - Bidir pins set as outputs ignore pin data writes; global values drive them.
// - Seven-bit transmit slot field selects slot 0..127; reset 0.
// - Transmit highway bit 7 picks first highway when clear, second when set.
// - Seven-bit receive slot field selects slot 0..127; reset 0.
// - Receive highway bit picks first highway when clear, second when set.
// - Low monitor returns sample low byte, or whole compressed byte.
// - Monitor reads never disturb the transmitted sample.
// - In linear mode high monitor returns sample bits 15..8.
// - In companded mode high monitor reads zero.
// - Registers selected by address; monitor registers are read only.
//
// The implementer's own choice: the APB interface to the registers.
`include "ccl_defines.svh"

module ccl_regs #(
  parameter int STEP_CYCLES = `CCL_STEP_CYCLES
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supervision inputs
  input wire logic hook_input,
  input wire logic ground_key_input,
  // Bidirectional line pins
  input wire logic line_bidir_pin_a_i,
  input wire logic line_bidir_pin_b_i,
  input wire logic line_bidir_pin_c_i,
  output logic line_bidir_pin_a_o,
  output logic line_bidir_pin_b_o,
  output logic line_bidir_pin_c_o,
  output logic line_bidir_pin_a_oe,
  output logic line_bidir_pin_b_oe,
  output logic line_bidir_pin_c_oe,
  // Output pins
  output logic line_output_a,
  output logic line_output_b,
  // Global output values for the bidir pins
  input wire logic global_bidir_a_output,
  input wire logic global_bidir_b_output,
  input wire logic global_bidir_c_output,
  // Transmit sample being sent
  input wire logic [15:0] tx_sample,
  // Loopback and PCM routing
  output logic digital_loop_timeslot,
  output logic analog_loop_onebit,
  output logic digital_loop_onebit,
  output ccl_pkg::ccl_slot_t transmit_slot_select,
  output logic transmit_highway_select,
  output ccl_pkg::ccl_slot_t receive_slot_select,
  output logic receive_highway_select,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] loop_ie_q;
  logic [7:0] deb_cfg_q;
  logic [1:0] so_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  ccl_pkg::ccl_irq_t status_q;
  ccl_pkg::ccl_irq_t status_d;
  ccl_pkg::ccl_irq_t mask_q;
  logic [3:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [2:0] bd_o_q;
  logic [2:0] bd_oe_q;
  logic [2:0] bd_prev_q;
  logic [1:0] deb_q;
  logic [1:0] deb_d;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  wire [5:0] idx = paddr[7:2];
  wire setup = psel & ~penable;
  wire done = psel & penable & pready_q;
  wire wr_done = done & pwrite & ~pslverr_q;
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_loop = (idx == `CCL_IDX_LOOP_IE);
  wire hit_deb = (idx == `CCL_IDX_DEBOUNCE);
  wire hit_pin = (idx == `CCL_IDX_PIN_DATA);
  wire hit_tx = (idx == `CCL_IDX_TX_SLOT);
  wire hit_rx = (idx == `CCL_IDX_RX_SLOT);
  wire hit_mlo = (idx == `CCL_IDX_MON_LOW);
  wire hit_mhi = (idx == `CCL_IDX_MON_HIGH);
  wire hit_sts = (idx == `CCL_IDX_IRQ_STATUS);
  wire hit_msk = (idx == `CCL_IDX_IRQ_MASK);
  wire hit_ctl = (idx == `CCL_IDX_CTRL);
  wire hit_rw = hit_loop | hit_deb | hit_pin | hit_tx | hit_rx | hit_msk | hit_ctl;
  wire hit_ro = hit_mlo | hit_mhi | hit_sts;
  // Read-only registers refuse the write form
  wire bad = ~aligned | ~(hit_rw | (hit_ro & ~pwrite));

  ////////////////////////////////////////////////////////////////////////
  // Live views of pins and sample
  wire linear = (ctrl_q[`CCL_CTRL_LINEAR] == ccl_pkg::CCL_LINEAR);
  wire [2:0] dir = ctrl_q[`CCL_CTRL_DIR_LSB +: 3];
  wire [2:0] bd_in = {line_bidir_pin_c_i, line_bidir_pin_b_i, line_bidir_pin_a_i};
  // An output pin reads back what is driven, an input what is seen
  wire [2:0] bd_view = (dir & bd_o_q) | (~dir & bd_in);
  wire [7:0] pin_view = {1'b0, so_q, bd_view, deb_q};
  // Monitor bytes are taps on the sample; the sample path is untouched
  wire [7:0] mon_lo = tx_sample[7:0];
  wire [7:0] mon_hi = linear ? tx_sample[15:8] : 8'h00;

  // Read multiplexer
  wire [7:0] rd_byte =
    hit_loop ? loop_ie_q :
    hit_deb ? deb_cfg_q :
    hit_pin ? pin_view :
    hit_tx ? tx_q :
    hit_rx ? rx_q :
    hit_mlo ? mon_lo :
    hit_mhi ? mon_hi :
    hit_sts ? {3'h0, status_q} :
    hit_msk ? {3'h0, mask_q} :
    hit_ctl ? {4'h0, ctrl_q} : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // APB answer: data captured in setup, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= setup;
      pslverr_q <= setup & bad;
      if (setup) begin
        prdata_q <= (bad | pwrite) ? 32'h0 : {24'h0, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_ie_q <= `CCL_RST_BYTE;
      deb_cfg_q <= `CCL_RST_BYTE;
      so_q <= 2'b00;
      tx_q <= `CCL_RST_BYTE;
      rx_q <= `CCL_RST_BYTE;
      mask_q <= `CCL_RST_IRQ;
      ctrl_q <= `CCL_RST_CTRL;
    end else if (ce && wr_done) begin
      if (hit_loop) loop_ie_q <= pwdata[7:0];
      if (hit_deb) deb_cfg_q <= pwdata[7:0];
      // Bidir bits of a pin write go nowhere; only the output pins take data
      if (hit_pin) so_q <= pwdata[6:5];
      if (hit_tx) tx_q <= pwdata[7:0];
      if (hit_rx) rx_q <= pwdata[7:0];
      if (hit_msk) mask_q <= pwdata[4:0];
      if (hit_ctl) ctrl_q <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bidir pin drivers follow the global values, never the pin data write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bd_o_q <= 3'b000;
      bd_oe_q <= 3'b000;
      bd_prev_q <= 3'b000;
    end else if (ce) begin
      bd_o_q <= {global_bidir_c_output, global_bidir_b_output,
                 global_bidir_a_output};
      bd_oe_q <= dir;
      bd_prev_q <= bd_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared 2 ms step prescaler; a restart is not aligned to it, so a
  // debounce may run up to one step short of whole steps.
  logic [$clog2(STEP_CYCLES)-1:0] pre_q;
  wire step = (pre_q == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (ce) begin
      pre_q <= step ? '0 : pre_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debounce per supervision input: hook waits code steps, ground key
  // waits six intervals of code steps each
  wire [1:0] raw = {ground_key_input, hook_input};
  for (genvar i = 0; i < 2; i++) begin : g_deb
    localparam int MULT = (i == 0) ? 1 : `CCL_GK_INTERVALS;
    wire [3:0] code = deb_cfg_q[4*i +: 4];
    wire [6:0] limit = 7'(code * MULT);
    logic [6:0] cnt_q;
    // Zero code passes straight through; otherwise wait for stability
    assign deb_d[i] = (code == 4'h0) ? raw[i] :
                      (raw[i] != deb_q[i] && step && cnt_q + 7'd1 >= limit) ?
                      raw[i] : deb_q[i];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= 7'h00;
      end else if (ce) begin
        if (raw[i] == deb_q[i] || code == 4'h0 || deb_d[i] != deb_q[i]) begin
          cnt_q <= 7'h00;
        end else if (step) begin
          cnt_q <= cnt_q + 7'd1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_q <= 2'b00;
    end else if (ce) begin
      deb_q <= deb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Change events, gated by enables and pin direction
  wire [2:0] bd_chg = (bd_in ^ bd_prev_q) & ~dir;
  wire [4:0] ev = {bd_chg, deb_d ^ deb_q} & loop_ie_q[`CCL_IE_LSB +: 5];
  // Read clears only the bits that were read out, so a later set survives
  wire [4:0] rd_clr = (done & ~pwrite & hit_sts) ? prdata_q[4:0] : 5'h00;
  assign status_d = (status_q & ~rd_clr) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `CCL_RST_IRQ;
      irq_q <= 1'b0;
    end else if (ce) begin
      status_q <= status_d;
      irq_q <= |(status_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign line_bidir_pin_a_o = bd_o_q[0];
  assign line_bidir_pin_b_o = bd_o_q[1];
  assign line_bidir_pin_c_o = bd_o_q[2];
  assign line_bidir_pin_a_oe = bd_oe_q[0];
  assign line_bidir_pin_b_oe = bd_oe_q[1];
  assign line_bidir_pin_c_oe = bd_oe_q[2];
  assign line_output_b = so_q[1];
  assign line_output_a = so_q[0];
  assign digital_loop_timeslot = loop_ie_q[2];
  assign analog_loop_onebit = loop_ie_q[1];
  assign digital_loop_onebit = loop_ie_q[0];
  assign transmit_slot_select = tx_q[6:0];
  assign transmit_highway_select = tx_q[`CCL_HIGHWAY_BIT];
  assign receive_slot_select = rx_q[6:0];
  assign receive_highway_select = rx_q[`CCL_HIGHWAY_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ie_gate;
    $rose(status_q[0]) |-> $past(loop_ie_q[3]);
  endproperty
  a_ie_gate: assert property (p_ie_gate)
    else $error("hook status set while disabled");

  property p_dir_gate;
    $rose(status_q[2]) |-> !$past(ctrl_q[1]);
  endproperty
  a_dir_gate: assert property (p_dir_gate)
    else $error("bidir a status set while output");

  property p_loop_wr;
    ce && wr_done && hit_loop |=> digital_loop_timeslot == $past(pwdata[2])
      && digital_loop_onebit == $past(pwdata[0]);
  endproperty
  a_loop_wr: assert property (p_loop_wr)
    else $error("loopback write not taken");

  property p_hook_pass;
    ce && deb_cfg_q[3:0] == 4'h0 |=> deb_q[0] == $past(hook_input);
  endproperty
  a_hook_pass: assert property (p_hook_pass)
    else $error("zero-code hook not passed");

  property p_gk_step;
    $changed(deb_q[1]) && $past(deb_cfg_q[7:4]) != 4'h0 |-> $past(step);
  endproperty
  a_gk_step: assert property (p_gk_step)
    else $error("ground key changed off step");

  property p_pin_rsv;
    done && !pwrite && hit_pin |-> prdata[7] == 1'b0;
  endproperty
  a_pin_rsv: assert property (p_pin_rsv)
    else $error("reserved pin bit set");

  property p_bd_drive;
    ce && dir[0] |=> line_bidir_pin_a_o == $past(global_bidir_a_output)
      && line_bidir_pin_a_oe;
  endproperty
  a_bd_drive: assert property (p_bd_drive)
    else $error("bidir a not driven from global");

  property p_tx_wr;
    ce && wr_done && hit_tx |=> transmit_slot_select == $past(pwdata[6:0])
      && transmit_highway_select == $past(pwdata[7]);
  endproperty
  a_tx_wr: assert property (p_tx_wr)
    else $error("transmit slot write not taken");

  property p_mon_lo;
    done && !pwrite && hit_mlo && $past(ce) |-> prdata[7:0] == $past(tx_sample[7:0]);
  endproperty
  a_mon_lo: assert property (p_mon_lo)
    else $error("low monitor mismatch");

  property p_mon_hi0;
    done && !pwrite && hit_mhi && !linear |-> prdata == 32'h0;
  endproperty
  a_mon_hi0: assert property (p_mon_hi0)
    else $error("high monitor not zero");

  property p_ro_err;
    done && pwrite && (hit_mlo || hit_mhi) |-> pslverr;
  endproperty
  a_ro_err: assert property (p_ro_err)
    else $error("monitor write accepted");

  property p_rx_wr;
    ce && wr_done && hit_rx |=> receive_slot_select == $past(pwdata[6:0])
      && receive_highway_select == $past(pwdata[7]);
  endproperty
  a_rx_wr: assert property (p_rx_wr)
    else $error("receive slot write not taken");

  // High byte is captured in setup, so compare with the sample one edge back
  property p_mon_hi;
    done && !pwrite && hit_mhi && linear && $past(ce)
      |-> prdata[7:0] == $past(tx_sample[15:8]);
  endproperty
  a_mon_hi: assert property (p_mon_hi)
    else $error("high monitor mismatch");

  c_irq: cover property (!irq ##1 irq);
  c_ro_err: cover property (done && pslverr);
  c_sts_rd: cover property (done && !pwrite && hit_sts && prdata[4:0] != 5'h0);
  c_gk_deb: cover property (deb_cfg_q[7:4] != 4'h0 ##0 $changed(deb_q[1]));

endmodule

/* hdl/ccl_defines.svh */
// Offsets, fields, reset values and timing counts of the channel register set
`ifndef CCL_DEFINES_SVH
`define CCL_DEFINES_SVH
// Register indexes; byte address is four times the index
`define CCL_IDX_LOOP_IE 6'h01
`define CCL_IDX_DEBOUNCE 6'h02
`define CCL_IDX_PIN_DATA 6'h03
`define CCL_IDX_TX_SLOT 6'h04
`define CCL_IDX_RX_SLOT 6'h05
`define CCL_IDX_MON_LOW 6'h06
`define CCL_IDX_MON_HIGH 6'h07
`define CCL_IDX_IRQ_STATUS 6'h08
`define CCL_IDX_IRQ_MASK 6'h09
`define CCL_IDX_CTRL 6'h0a
// Field positions
`define CCL_IE_LSB 3
`define CCL_HIGHWAY_BIT 7
`define CCL_CTRL_LINEAR 0
`define CCL_CTRL_DIR_LSB 1
// Reset values
`define CCL_RST_BYTE 8'h00
`define CCL_RST_IRQ 5'h00
`define CCL_RST_CTRL 4'h0
// Timing: one debounce step, and the ground-key interval multiple
`define CCL_STEP_MS 2
`define CCL_CLK_KHZ 25000
`define CCL_STEP_CYCLES (`CCL_STEP_MS * `CCL_CLK_KHZ)
`define CCL_GK_INTERVALS 6
`endif

/* hdl/ccl_pkg.sv */
// Types shared by the channel register set
package ccl_pkg;
  typedef enum logic {CCL_COMPANDED, CCL_LINEAR} ccl_code_t;
  typedef logic [6:0] ccl_slot_t;
  typedef logic [4:0] ccl_irq_t;
endpackage

/* verification/ccl_host.sv */
// Host model that issues register commands to the channel register set over APB
module ccl_host (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // One transfer; an idle edge first, so two calls never drive psel twice at one step
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count is assumed; a hung slave is left to the bench watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* verification/ccl_regs_tb.sv */
// Self-checking bench of the channel register set
module ccl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, psel, penable, pwrite, pready, pslverr, irq;
  logic presetn = 1'b0, ce = 1'b1;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic hook_input = 1'b0, ground_key_input = 1'b0;
  logic line_bidir_pin_a_i = 1'b0, line_bidir_pin_b_i = 1'b0, line_bidir_pin_c_i = 1'b0;
  logic line_bidir_pin_a_o, line_bidir_pin_b_o, line_bidir_pin_c_o;
  logic line_bidir_pin_a_oe, line_bidir_pin_b_oe, line_bidir_pin_c_oe;
  logic global_bidir_a_output = 1'b0, global_bidir_b_output = 1'b0;
  logic global_bidir_c_output = 1'b0;
  logic [15:0] tx_sample = 16'h0000;
  logic line_output_a, line_output_b, transmit_highway_select, receive_highway_select;
  logic digital_loop_timeslot, analog_loop_onebit, digital_loop_onebit;
  ccl_pkg::ccl_slot_t transmit_slot_select, receive_slot_select;
  int failures = 0;
  int comparisons = 0;
  // Short debounce step keeps the run brief
  ccl_regs #(.STEP_CYCLES(4)) DUT (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .hook_input, .ground_key_input, .line_bidir_pin_a_i, .line_bidir_pin_b_i,
    .line_bidir_pin_c_i, .line_bidir_pin_a_o, .line_bidir_pin_b_o, .line_bidir_pin_c_o,
    .line_bidir_pin_a_oe, .line_bidir_pin_b_oe, .line_bidir_pin_c_oe, .line_output_a,
    .line_output_b, .global_bidir_a_output, .global_bidir_b_output,
    .global_bidir_c_output, .tx_sample, .digital_loop_timeslot, .analog_loop_onebit,
    .digital_loop_onebit, .transmit_slot_select, .transmit_highway_select,
    .receive_slot_select, .receive_highway_select, .irq
  );
  ccl_host HOST (
    .pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
  );
  //////////////////////////////////////////////////////////////////////////////
  // Compare, bus and wait helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic e);
    logic [31:0] r;
    logic x;
    HOST.xfer(1'b1, i, d, r, x);
    chk(x, e);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic x;
    HOST.xfer(1'b0, i, 8'h00, r, x);
    chk(x, 1'b0);
    chk(r, {24'h000000, d});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rd(6'h01, 8'h00);
    rd(6'h02, 8'h00);
    rd(6'h03, 8'h00);
    rd(6'h04, 8'h00);
    rd(6'h05, 8'h00);
    chk({digital_loop_timeslot, analog_loop_onebit, digital_loop_onebit}, 3'h0);
    chk(irq, 1'b0);
  endtask
  task automatic t_rw;
    wr(6'h01, 8'h05, 1'b0);
    cyc(1);
    chk({digital_loop_timeslot, analog_loop_onebit, digital_loop_onebit}, 3'h5);
    wr(6'h04, 8'h85, 1'b0);
    wr(6'h05, 8'h7f, 1'b0);
    cyc(1);
    chk({transmit_highway_select, transmit_slot_select}, 8'h85);
    chk({receive_highway_select, receive_slot_select}, 8'h7f);
    wr(6'h05, 8'h80, 1'b0);
    cyc(1);
    chk({receive_highway_select, receive_slot_select}, 8'h80);
    rd(6'h01, 8'h05);
    rd(6'h04, 8'h85);
    // Reset in mid-run must bring back the reset values of registers 1 to 5, the loopback outputs and irq
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    t_reset();
  endtask
  task automatic t_mon;
    logic [31:0] r;
    logic x;
    tx_sample <= 16'ha55a;
    rd(6'h06, 8'h5a);
    rd(6'h07, 8'h00);
    wr(6'h0a, 8'h01, 1'b0);
    rd(6'h06, 8'h5a);
    rd(6'h07, 8'ha5);
    wr(6'h06, 8'hff, 1'b1);
    wr(6'h07, 8'hff, 1'b1);
    rd(6'h07, 8'ha5);
    HOST.xfer(1'b0, 6'h0b, 8'h00, r, x);
    chk(x, 1'b1);
    wr(6'h0a, 8'h00, 1'b0);
  endtask
  task automatic t_irq;
    wr(6'h09, 8'h1f, 1'b0);
    wr(6'h01, 8'h20, 1'b0);
    line_bidir_pin_a_i <= 1'b1;
    cyc(4);
    chk(irq, 1'b1);
    rd(6'h08, 8'h04);
    cyc(2);
    chk(irq, 1'b0);
    line_bidir_pin_b_i <= 1'b1;
    cyc(4);
    chk(irq, 1'b0);
    wr(6'h0a, 8'h02, 1'b0);
    line_bidir_pin_a_i <= 1'b0;
    cyc(4);
    chk(irq, 1'b0);
    wr(6'h09, 8'h00, 1'b0);
    wr(6'h0a, 8'h00, 1'b0);
    line_bidir_pin_a_i <= 1'b1;
    cyc(4);
    chk(irq, 1'b0);
    rd(6'h08, 8'h04);
    wr(6'h01, 8'h00, 1'b0);
  endtask
  task automatic t_pins;
    wr(6'h0a, 8'h02, 1'b0);
    wr(6'h03, 8'h64, 1'b0);
    cyc(2);
    chk({line_bidir_pin_a_oe, line_bidir_pin_a_o}, 2'h2);
    chk({line_output_b, line_output_a}, 2'h3);
    global_bidir_a_output <= 1'b1;
    cyc(2);
    chk(line_bidir_pin_a_o, 1'b1);
    rd(6'h03, 8'h6c);
    // Clock enable low must freeze the pin drivers
    ce <= 1'b0;
    global_bidir_a_output <= 1'b0;
    cyc(3);
    chk(line_bidir_pin_a_o, 1'b1);
    ce <= 1'b1;
    cyc(2);
    chk(line_bidir_pin_a_o, 1'b0);
    wr(6'h0a, 8'h00, 1'b0);
  endtask
  task automatic t_deb;
    wr(6'h09, 8'h03, 1'b0);
    wr(6'h01, 8'h18, 1'b0);
    wr(6'h02, 8'h02, 1'b0);
    hook_input <= 1'b1;
    cyc(2);
    chk(irq, 1'b0);
    cyc(16);
    chk(irq, 1'b1);
    rd(6'h08, 8'h01);
    hook_input <= 1'b0;
    cyc(2);
    hook_input <= 1'b1;
    cyc(16);
    rd(6'h08, 8'h00);
    wr(6'h02, 8'h00, 1'b0);
    hook_input <= 1'b0;
    cyc(5);
    chk(irq, 1'b1);
    rd(6'h08, 8'h01);
    wr(6'h02, 8'h10, 1'b0);
    ground_key_input <= 1'b1;
    cyc(12);
    chk(irq, 1'b0);
    cyc(20);
    chk(irq, 1'b1);
    rd(6'h08, 8'h02);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Clock, sequence, verdict and watchdog
  task automatic end_of_test;
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rw();
    t_mon();
    t_irq();
    t_pins();
    t_deb();
    end_of_test();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
